// >>> hdl/ssl_pkg.sv
// Constants for the serial shift latch block
// Function
// - Clear low zeroes all shift stages
// - Shift edge moves register, loads serial bit
// - No shift edge holds register contents
// - Latch edge copies all stages in parallel
// - Without latch edge, latch keeps contents
// - Enable low drives outputs, high floats them
// - Tied clocks: latch lags one pulse
package ssl_pkg;
	localparam int          SSL_WIDTH     = 8;
	localparam int          SSL_FIFO_DEP  = 8;
	localparam int          SSL_SYNC_LEN  = 3;
	localparam logic [7:0]  SSL_RST_VAL   = 8'h00;
	localparam logic [2:0]  SSL_SYNC_RST  = 3'h0;
	localparam logic [1:0]  SSL_RSTS_VAL  = 2'h0;
endpackage

// >>> hdl/ssl_fifo_if.sv
// Valid/ready carrier between shift-latch core and its FIFO
`timescale 1ns/1ps
interface ssl_fifo_if #(
	parameter int WIDTH = 8
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// >>> hdl/ssl_fifo.sv
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
module ssl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	// Fill and drain sides
	ssl_fifo_if.snk   fill,
	ssl_fifo_if.src   drain
);
	localparam int AW = $clog2(DEPTH);

	// Pointer wrap needs a power-of-two depth, refused at elaboration
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("ssl_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0]      wr_ff;
	logic [AW:0]      rd_ff;
	logic [AW:0]      nxt_wr;
	logic [AW:0]      nxt_rd;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	// Extra pointer bit tells full from empty
	always_comb begin
		full        = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
		empty       = (wr_ff == rd_ff);
		fill.ready  = !full;
		drain.valid = !empty;
		drain.data  = mem_ff[rd_ff[AW-1:0]];
		push        = fill.valid && !full;
		pop         = drain.ready && !empty;
		nxt_wr      = push ? wr_ff + 1'b1 : wr_ff;
		nxt_rd      = pop ? rd_ff + 1'b1 : rd_ff;
	end

	// Pointer registers
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
		end
	end

	// Storage has no reset, so it maps to plain RAM
	always_ff @(posedge i_core_clk) begin
		if (push)
			mem_ff[wr_ff[AW-1:0]] <= fill.data;
	end
endmodule

// >>> hdl/ssl_top.sv
// Serial-in shift register with storage latch, three-state outputs and cascade
`timescale 1ns/1ps
module ssl_top
	import ssl_pkg::*;
#(
	parameter int WIDTH = ssl_pkg::SSL_WIDTH,
	parameter int DEPTH = ssl_pkg::SSL_FIFO_DEP
) (
	// Clock and reset
	input  wire logic             i_core_clk,
	input  wire logic             i_resetn,
	// Controller pins
	input  wire logic             i_bit_stream_in,
	input  wire logic             i_shift_clock,
	input  wire logic             i_latch_clock,
	input  wire logic             i_shift_clear_n,
	input  wire logic             i_out_enable_n,
	// Parallel outputs and their per-pin enables
	output logic [WIDTH-1:0]      o_par_out,
	output logic [WIDTH-1:0]      o_par_oe,
	// Cascade output
	output logic                  o_cascade,
	// Latched word stream, flags lost words while full
	output logic                  o_word_valid,
	output logic [WIDTH-1:0]      o_word_data,
	input  wire logic             i_word_ready,
	output logic                  o_word_drop
);
	import ssl_pkg::*;

	// The core is laid out for one byte; other widths are refused at elaboration
	if (WIDTH != SSL_WIDTH) begin : g_bad_width
		$error("ssl_top: WIDTH must be 8");
	end

	// Reset release synchroniser: asserts at once, releases two edges later
	// so that every flop leaves reset in the same cycle
	logic [1:0] rst_sync_ff;
	logic [1:0] nxt_rst_sync;
	logic       rst_n;
	always_comb begin
		nxt_rst_sync = {rst_sync_ff[0], 1'b1};
	end
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			rst_sync_ff <= SSL_RSTS_VAL;
		else
			rst_sync_ff <= nxt_rst_sync;
	end
	assign rst_n = rst_sync_ff[1];

	// Three-stage pin synchronisers; stage 0 feeds stage 1 only
	logic [SSL_SYNC_LEN-1:0] sy_ser_ff;
	logic [SSL_SYNC_LEN-1:0] sy_sck_ff;
	logic [SSL_SYNC_LEN-1:0] sy_lck_ff;
	logic [SSL_SYNC_LEN-1:0] sy_clr_ff;
	logic [SSL_SYNC_LEN-1:0] sy_oe_ff;
	logic [SSL_SYNC_LEN-1:0] nxt_sy_ser;
	logic [SSL_SYNC_LEN-1:0] nxt_sy_sck;
	logic [SSL_SYNC_LEN-1:0] nxt_sy_lck;
	logic [SSL_SYNC_LEN-1:0] nxt_sy_clr;
	logic [SSL_SYNC_LEN-1:0] nxt_sy_oe;
	always_comb begin
		nxt_sy_ser = {sy_ser_ff[1:0], i_bit_stream_in};
		nxt_sy_sck = {sy_sck_ff[1:0], i_shift_clock};
		nxt_sy_lck = {sy_lck_ff[1:0], i_latch_clock};
		nxt_sy_clr = {sy_clr_ff[1:0], i_shift_clear_n};
		nxt_sy_oe  = {sy_oe_ff[1:0], i_out_enable_n};
	end
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sy_ser_ff <= SSL_SYNC_RST;
			sy_sck_ff <= SSL_SYNC_RST;
			sy_lck_ff <= SSL_SYNC_RST;
			sy_clr_ff <= SSL_SYNC_RST;
			sy_oe_ff  <= '1;    // Outputs float until the enable is seen low
		end else begin
			sy_ser_ff <= nxt_sy_ser;
			sy_sck_ff <= nxt_sy_sck;
			sy_lck_ff <= nxt_sy_lck;
			sy_clr_ff <= nxt_sy_clr;
			sy_oe_ff  <= nxt_sy_oe;
		end
	end

	// Filtered levels: a change counts once stages 1 and 2 agree
	logic ser_q;
	logic sck_q;
	logic lck_q;
	logic clr_n_q;
	logic oe_n_q;
	logic ser_ff;
	logic sck_ff;
	logic lck_ff;
	logic clr_n_ff;
	logic oe_n_ff;
	function automatic logic filt(input logic [2:0] s, input logic prev);
		filt = (s[1] == s[2]) ? s[2] : prev;
	endfunction
	always_comb begin
		ser_q   = filt(sy_ser_ff, ser_ff);
		sck_q   = filt(sy_sck_ff, sck_ff);
		lck_q   = filt(sy_lck_ff, lck_ff);
		clr_n_q = filt(sy_clr_ff, clr_n_ff);
		oe_n_q  = filt(sy_oe_ff, oe_n_ff);
	end

	// Core state
	logic [WIDTH-1:0] shreg_ff;
	logic [WIDTH-1:0] nxt_shreg;
	logic [WIDTH-1:0] latch_ff;
	logic [WIDTH-1:0] nxt_latch;
	logic             shift_edge;
	logic             latch_edge;
	logic             fifo_full;
	logic [WIDTH-1:0] nxt_par_out;
	logic [WIDTH-1:0] nxt_par_oe;
	logic             nxt_cascade;
	logic             nxt_drop;
	ssl_fifo_if #(.WIDTH(WIDTH)) f_in ();
	ssl_fifo_if #(.WIDTH(WIDTH)) f_out ();

	// Rising edge of a filtered level against its value one cycle earlier
	function automatic logic rise(input logic now_lvl, input logic was_lvl);
		rise = now_lvl && !was_lvl;
	endfunction

	// A full buffer never holds the pins back: stalling here would swallow
	// shift edges, so only the copy toward the word stream is lost
	assign fifo_full = !f_in.ready;

	// Previous filtered levels; clear starts asserted and outputs floating
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_ff   <= 1'b0;
			sck_ff   <= 1'b0;
			lck_ff   <= 1'b0;
			clr_n_ff <= 1'b0;
			oe_n_ff  <= 1'b1;
		end else begin
			ser_ff   <= ser_q;
			sck_ff   <= sck_q;
			lck_ff   <= lck_q;
			clr_n_ff <= clr_n_q;
			oe_n_ff  <= oe_n_q;
		end
	end

	// Shift register and latch next values
	always_comb begin
		shift_edge = rise(sck_q, sck_ff);
		latch_edge = rise(lck_q, lck_ff);
		nxt_shreg  = shreg_ff;
		if (!clr_n_q)
			nxt_shreg = SSL_RST_VAL;
		else if (shift_edge)
			nxt_shreg = {shreg_ff[WIDTH-2:0], ser_q};
		// Latch takes pre-edge stages, so tied clocks lag one pulse
		nxt_latch = latch_edge ? shreg_ff : latch_ff;
	end

	// Shift register and latch; clear reaches the shift register only
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shreg_ff <= SSL_RST_VAL;
			latch_ff <= SSL_RST_VAL;
		end else begin
			shreg_ff <= nxt_shreg;
			latch_ff <= nxt_latch;
		end
	end

	// Output next values; a latch edge into a full buffer is flagged, not held off
	always_comb begin
		nxt_par_out = nxt_latch;
		nxt_par_oe  = oe_n_q ? '0 : '1;
		nxt_cascade = nxt_shreg[WIDTH-1];
		nxt_drop    = latch_edge && fifo_full;
		f_in.valid  = latch_edge;
		f_in.data   = shreg_ff;
	end

	// Pin outputs come straight from these flops
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_par_out   <= SSL_RST_VAL;
			o_par_oe    <= '0;
			o_cascade   <= 1'b0;
			o_word_drop <= 1'b0;
		end else begin
			o_par_out   <= nxt_par_out;
			o_par_oe    <= nxt_par_oe;
			o_cascade   <= nxt_cascade;
			o_word_drop <= nxt_drop;
		end
	end

	// Latched words buffered toward the user side
	ssl_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_fifo (
		.i_core_clk (i_core_clk),
		.i_rst_n    (rst_n),
		.fill       (f_in.snk),
		.drain      (f_out.src)
	);

	// Output stage registers the FIFO head, skid-free one-word holder
	logic             nxt_wv;
	logic [WIDTH-1:0] nxt_wd;
	always_comb begin
		f_out.ready = !o_word_valid || i_word_ready;
		nxt_wv      = f_out.ready ? f_out.valid : o_word_valid;
		nxt_wd      = (f_out.ready && f_out.valid) ? f_out.data : o_word_data;
	end
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_word_valid <= 1'b0;
			o_word_data  <= SSL_RST_VAL;
		end else begin
			o_word_valid <= nxt_wv;
			o_word_data  <= nxt_wd;
		end
	end
endmodule

// >>> verif/ssl_top_assertions.sv
// Port checks of the shift latch top
`timescale 1ns/1ps
module ssl_top_assertions #(
	parameter int WIDTH = 8
) (
	input wire logic             i_core_clk,
	input wire logic             i_resetn,
	input wire logic             i_shift_clock,
	input wire logic             i_latch_clock,
	input wire logic             i_shift_clear_n,
	input wire logic             i_out_enable_n,
	input wire logic [WIDTH-1:0] o_par_out,
	input wire logic [WIDTH-1:0] o_par_oe,
	input wire logic             o_cascade,
	input wire logic             o_word_valid,
	input wire logic [WIDTH-1:0] o_word_data,
	input wire logic             i_word_ready,
	input wire logic             o_word_drop
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	// Quiet pin spans; eight cycles outlast the pin sync latency
	sequence s_no_latch; (!i_latch_clock)[*8]; endsequence
	sequence s_no_shift; (i_shift_clear_n && !i_shift_clock)[*8]; endsequence
	a_oe_whole: assert property (o_par_oe == '0 || o_par_oe == '1)
		else $error("enable bits split");
	a_enable_on: assert property ((!i_out_enable_n)[*8] |=> o_par_oe == '1)
		else $error("outputs not driven");
	a_enable_off: assert property (i_out_enable_n[*8] |=> o_par_oe == '0)
		else $error("outputs not floating");
	a_clear_zero: assert property ((!i_shift_clear_n)[*8] |=> !o_cascade)
		else $error("clear left last stage set");
	a_latch_hold: assert property (s_no_latch |=> $stable(o_par_out))
		else $error("latch moved without edge");
	a_shift_hold: assert property (s_no_shift |=> $stable(o_cascade))
		else $error("shift moved without edge");
	a_word_hold: assert property (o_word_valid && !i_word_ready |=>
		o_word_valid && $stable(o_word_data)) else $error("word lost in stall");
	a_drop_full: assert property (o_word_drop |-> o_word_valid)
		else $error("drop with room left");
endmodule
bind ssl_top ssl_top_assertions #(.WIDTH(WIDTH)) chk_u (.*);

// >>> verif/ssl_ctl_model.sv
// Controller model driving the shift latch pins
`timescale 1ns/1ps
module ssl_ctl_model (
	input  wire logic i_core_clk,
	output logic      o_bit_stream_in,
	output logic      o_shift_clock,
	output logic      o_latch_clock,
	output logic      o_shift_clear_n,
	output logic      o_out_enable_n
);
	// Idle pins, outputs floating
	initial begin
		o_bit_stream_in = 1'b0;
		o_shift_clock = 1'b0;
		o_latch_clock = 1'b0;
		o_shift_clear_n = 1'b1;
		o_out_enable_n = 1'b1;
	end
	// Six cycles per level, above what the sync filter needs
	task automatic hold();
		repeat (6) @(posedge i_core_clk);
		#1;
	endtask
	// Tying both clocks gives the one pulse lag
	task automatic pulse(input logic b, input logic s, input logic l);
		o_bit_stream_in = b;
		hold();
		o_shift_clock = s;
		o_latch_clock = l;
		hold();
		o_bit_stream_in = ~b; // Data no longer held
		o_shift_clock = 1'b0;
		o_latch_clock = 1'b0;
		hold();
	endtask
	task automatic clear();
		o_shift_clear_n = 1'b0;
		repeat (2) hold();
		o_shift_clear_n = 1'b1;
		hold();
	endtask
	task automatic enable(input logic on);
		o_out_enable_n = ~on;
		repeat (2) hold();
	endtask
endmodule

// >>> verif/ssl_top_tb_top.sv
// Self-checking bench for the shift latch
`timescale 1ns/1ps
module ssl_top_tb_top;
	logic       clk;
	logic       rst_n;
	logic       ready;
	logic       bit_stream_in, sck, lck, clr_n, oe_n, casc, wvalid, drop;
	logic [7:0] par, oe, wdata, last_w;
	int         n_mismatch = 0, samples_checked = 0, n_words = 0, n_drops = 0;
	ssl_ctl_model ctl_u (.i_core_clk(clk), .o_bit_stream_in(bit_stream_in), .o_shift_clock(sck),
		.o_latch_clock(lck), .o_shift_clear_n(clr_n), .o_out_enable_n(oe_n));
	ssl_top dut_u (.i_core_clk(clk), .i_resetn(rst_n), .i_bit_stream_in(bit_stream_in),
		.i_shift_clock(sck), .i_latch_clock(lck), .i_shift_clear_n(clr_n),
		.i_out_enable_n(oe_n), .o_par_out(par), .o_par_oe(oe), .o_cascade(casc),
		.o_word_valid(wvalid), .o_word_data(wdata), .i_word_ready(ready),
		.o_word_drop(drop));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Word stream monitor
	always @(posedge clk) begin
		if (wvalid === 1'b1 && ready === 1'b1) begin
			last_w <= wdata;
			n_words <= n_words + 1;
		end
		if (drop === 1'b1) n_drops <= n_drops + 1;
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// First bit sent ends in the last stage
	task automatic t_load();
		logic [7:0] w;
		w = 8'ha5;
		for (int i = 7; i >= 0; i--) ctl_u.pulse(w[i], 1'b1, 1'b0);
		ctl_u.pulse(1'b0, 1'b0, 1'b1);
		chk("par", par, 8'ha5);
		chk("casc", {7'h00, casc}, 8'h01);
		chk("word", last_w, 8'ha5);
	endtask
	task automatic t_enable();
		ctl_u.enable(1'b1);
		chk("oe on", oe, 8'hff);
		ctl_u.enable(1'b0);
		chk("oe off", oe, 8'h00);
	endtask
	task automatic t_clear();
		ctl_u.clear();
		chk("casc clr", {7'h00, casc}, 8'h00);
		chk("par kept", par, 8'ha5);
		ctl_u.pulse(1'b1, 1'b0, 1'b1);
		chk("par clr", par, 8'h00);
	endtask
	task automatic t_tied();
		repeat (2) ctl_u.pulse(1'b1, 1'b1, 1'b1);
		chk("par tied", par, 8'h01);
	endtask
	// Stalled consumer: nine words held, tenth edge dropped
	task automatic t_full();
		int w0;
		w0 = n_words;
		ready = 1'b0;
		repeat (10) ctl_u.pulse(1'b0, 1'b0, 1'b1);
		chk("drops", n_drops[7:0], 8'h01);
		ready = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		chk("drained", 8'(n_words - w0), 8'h09);
	endtask
	initial begin
		rst_n = 1'b0;
		ready = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		t_load();
		t_enable();
		t_clear();
		t_tied();
		t_full();
		final_report();
	end
	// Run takes about 480 cycles
	initial begin
		#40000;
		n_mismatch++;
		final_report();
	end
endmodule
